// >>> bench/hcd_enc_model.sv
`timescale 1ns/1ns
// ==========================================================
// Remote encoder stand-in: drives the shaped serial line
module hcd_enc_model #(
   parameter int SDIV = 4
) (
   // Clock and line
   input wire logic clk_i,
   output logic serial_o
);
   // Line rests low between frames, like the blank interval
   initial serial_o = 1'b0;

   // Hold one level for a number of sample ticks
   task automatic level(input logic v, input int samples);
      serial_o <= v;
      repeat (samples * SDIV) @(posedge clk_i);
   endtask

   // One symbol, 110 or 100, ten samples per bit
   task automatic sym(input logic b);
      level(1'b1, 10);
      level(b, 10);
      level(1'b0, 10);
   endtask

   // Precode, code MSB first, then both packets function 1 first
   // A cut frame slips a short pulse in three pulses before the code
   task automatic send(input logic [39:0] code, input logic [3:0] p1, input logic [3:0] p2,
                       input logic cut);
      for (int i = 0; i < 24; i++) begin
         if (cut && i == 21) begin
            level(1'b1, 3);
            level(1'b0, 3);
         end
         level(1'b1, 10);
         level(1'b0, 10);
      end
      for (int i = 39; i >= 0; i--) sym(code[i]);
      for (int i = 0; i < 4; i++) sym(p1[i]);
      for (int i = 0; i < 4; i++) sym(p2[i]);
      serial_o <= 1'b0;
   endtask
endmodule

// >>> bench/hopping_code_decoder_learn_tb_top.sv
`timescale 1ns/1ns
module hopping_code_decoder_learn_tb_top;
   // ==========================================================
   // Signals and settings
   localparam int SDIV = 4;
   localparam int BITCLK = SDIV * 10;
   localparam logic [39:0] CODE_A = 40'h5a_c3_96_e1_27;
   localparam logic [39:0] CODE_B = 40'h5a_c3_96_e1_26;
   typedef struct packed {
      logic [39:0] code;
      logic [3:0] p1;
      logic [3:0] p2;
      logic [3:0] lines;
   } hcd_row_t;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic program_request_pin = 1'b0;
   logic cfg = 1'b0;
   logic ce = 1'b1;
   logic serial;
   logic bclk, bclk_d;
   int n_rise;
   logic [39:0] code_seen;
   logic [3:0] lines_n;
   logic lamp_n;
   logic dmode;
   int fail_count = 0;
   int cmp_count = 0;
   // One near-miss code and a split packet leave lines alone
   hcd_row_t rows [5] = '{
      '{CODE_A, 4'he, 4'he, 4'he}, '{CODE_A, 4'h7, 4'hb, 4'he},
      '{CODE_B, 4'h3, 4'h3, 4'he}, '{CODE_A, 4'hf, 4'hf, 4'hf},
      '{CODE_A, 4'hc, 4'hc, 4'hc}};

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   // ==========================================================
   // Design and far side
   hcd_decoder #(.SCLK_DIV(SDIV), .FIFO_DEPTH(16)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
      .config_select_pin_i(cfg), .program_request_pin_i(program_request_pin),
      .serial_in_i(serial), .function_lines_n_o(lines_n),
      .status_lamp_n_o(lamp_n), .bit_clock_o(bclk), .decoder_mode_o(dmode));
   hcd_enc_model #(.SDIV(SDIV)) enc (.clk_i(clk_i), .serial_o(serial));

   // ==========================================================
   // Compare and close
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog sized above the ~87k cycles the sequence needs
   initial begin
      repeat (100000) @(posedge clk_i);
      fail_count++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check(lines_n, 4'hf);
      check(lamp_n, 1'b1);
      check(dmode, 1'b1);
      // Learn: lamp lights, first frame stored, lamp goes out
      @(posedge clk_i);
      program_request_pin <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      check(lamp_n, 1'b0);
      @(posedge clk_i);
      enc.send(CODE_A, 4'he, 4'he, 1'b0);
      for (int n = 0; n < 100 && lamp_n !== 1'b1; n++) @(posedge clk_i);
      check(lamp_n, 1'b1);
      program_request_pin <= 1'b0;
      // Table of frames and the lines each should leave
      foreach (rows[i]) begin
         @(posedge clk_i);
         enc.send(rows[i].code, rows[i].p1, rows[i].p2, 1'b0);
         repeat (40) @(posedge clk_i);
         #1;
         check(lines_n, rows[i].lines);
      end
      // Hold: still active before 768 bit times, released after
      repeat (700 * BITCLK) @(posedge clk_i);
      #1;
      check(lines_n, 4'hc);
      repeat (100 * BITCLK) @(posedge clk_i);
      #1;
      check(lines_n, 4'hf);
      // Precode cut short: the frame must be dropped, lines stay idle
      @(posedge clk_i);
      enc.send(CODE_A, 4'h3, 4'h3, 1'b1);
      repeat (40) @(posedge clk_i);
      #1;
      check(lines_n, 4'hf);
      // Learn left with no frame seen keeps the lamp lit
      @(posedge clk_i);
      program_request_pin <= 1'b1;
      repeat (3) @(posedge clk_i);
      program_request_pin <= 1'b0;
      repeat (BITCLK) @(posedge clk_i);
      #1;
      check(lamp_n, 1'b0);
      // Bit clock: ten rising edges in ten bit periods
      bclk_d = bclk;
      n_rise = 0;
      repeat (10 * BITCLK) begin
         @(posedge clk_i);
         #1;
         if (bclk && !bclk_d) n_rise++;
         bclk_d = bclk;
      end
      check(n_rise, 10);
      // Enable low for half a bit: a running bit clock would have flipped
      @(posedge clk_i);
      ce <= 1'b0;
      @(posedge clk_i);
      #1;
      bclk_d = bclk;
      repeat (BITCLK / 2) @(posedge clk_i);
      #1;
      check(bclk, bclk_d);
      check(lamp_n, 1'b0);
      @(posedge clk_i);
      ce <= 1'b1;
      // Second reset with the pin high: encoder programming, twice
      @(posedge clk_i);
      cfg <= 1'b1;
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check(dmode, 1'b0);
      check(lamp_n, 1'b1);
      code_seen = dut.banks[0].code;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         program_request_pin <= 1'b1;
         @(posedge clk_i);
         #1;
         check(lamp_n, 1'b0);
         repeat (BITCLK + 3) @(posedge clk_i);
         #1;
         check(lamp_n, 1'b1);
         check(dut.banks[0].code == code_seen, 1'b0);
         code_seen = dut.banks[0].code;
         @(posedge clk_i);
         program_request_pin <= 1'b0;
      end
      conclude();
   end
endmodule

// >>> hdl/hcd_decoder.sv
`timescale 1ns/1ns
module hcd_decoder #(
   parameter int SCLK_DIV = hcd_pkg::SCLK_DIV_CYC,
   parameter int FIFO_DEPTH = hcd_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Configuration and programming pins
   input wire logic config_select_pin_i,
   input wire logic program_request_pin_i,
   // Received serial line, already shaped to logic levels
   input wire logic serial_in_i,
   // Pin outputs
   output logic [3:0] function_lines_n_o,
   output logic status_lamp_n_o,
   output logic bit_clock_o,
   output logic decoder_mode_o
);
   typedef enum logic [1:0] {SY_SEARCH, SY_ARMED, SY_DATA} hcd_sync_t;
   typedef enum logic {AS_COLLECT, AS_EVAL} hcd_asm_t;

   typedef struct packed {
      logic [15:0] scl_cnt;
      logic [3:0] bit_cnt;
      logic bclk;
      logic line_d;
      logic [7:0] per_cnt;
      logic sym_busy;
      logic [4:0] smp_idx;
      logic [3:0] nsmp;
      logic [3:0] ones;
      hcd_sync_t sync;
      logic [4:0] pre_cnt;
      logic [5:0] sym_cnt;
      logic pend;
      hcd_pkg::hcd_sym_t pend_sym;
      hcd_asm_t asm_st;
      logic [5:0] fr_cnt;
      logic [47:0] shreg;
      logic enc_mode;
      logic learn_act;
      logic learned;
      logic enc_busy;
      logic program_request_pin_d;
      logic [1:0] next_bank;
      logic [39:0] lfsr;
      logic we;
      logic [1:0] wbank;
      hcd_pkg::hcd_bank_t wdata;
      logic [3:0] func_n;
      logic [9:0] hold;
      logic lamp_n;
   } hcd_dec_st_t;

   hcd_dec_st_t st_reg, st_next;
   logic samp, btick, rise, per_pre, program_request_pin_rise;
   logic sym_done, sym_bad, load_fn, kill_fn, match_any;
   logic [3:0] ones_tot, fn1, fn2;
   logic [4:0] smp_pos, idx_n;
   logic [39:0] sec;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   hcd_pkg::hcd_sym_t fifo_out;
   hcd_pkg::hcd_bank_t [hcd_pkg::BANKS-1:0] banks;

   // ==========================================================
   // Timing strobes: sample tick and bit tick (one in ten)
   assign samp = ce_i && (st_reg.scl_cnt == '0);
   assign btick = samp && (st_reg.bit_cnt == '0);
   assign rise = serial_in_i && !st_reg.line_d;
   assign per_pre = (st_reg.per_cnt >= hcd_pkg::PRE_PER_MIN) &&
                    (st_reg.per_cnt <= hcd_pkg::PRE_PER_MAX);
   assign program_request_pin_rise = program_request_pin_i && !st_reg.program_request_pin_d;
   // Integrator reads every third sample, starting two after the edge
   assign smp_pos = hcd_pkg::SYM_FIRST + 5'(st_reg.nsmp) * hcd_pkg::SYM_SPACING;
   assign idx_n = st_reg.smp_idx + 5'h01;
   assign ones_tot = st_reg.ones + {3'h0, serial_in_i};

   // Frame fields: security first, then the two function packets
   assign sec = st_reg.shreg[47:8];
   assign fn1 = st_reg.shreg[7:4];
   assign fn2 = st_reg.shreg[3:0];
   assign fifo_out_ready = (st_reg.asm_st == AS_COLLECT);

   // Match against every bank whose check byte is sound
   always_comb begin
      match_any = 1'b0;
      for (int b = 0; b < hcd_pkg::BANKS; b++) begin
         if (banks[b].code == sec && banks[b].chk == hcd_pkg::hcd_chk(banks[b].code)) begin
            match_any = 1'b1;
         end
      end
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      st_next = st_reg;
      sym_done = 1'b0;
      sym_bad = 1'b0;
      load_fn = 1'b0;
      kill_fn = 1'b0;
      if (ce_i) begin
         st_next.we = 1'b0;
         st_next.lfsr = {st_reg.lfsr[38:0],
                         st_reg.lfsr[39] ^ st_reg.lfsr[37] ^ st_reg.lfsr[20] ^ st_reg.lfsr[18]};
         st_next.scl_cnt = samp ? 16'(SCLK_DIV - 1) : st_reg.scl_cnt - 16'h0001;
         // Sample-rate work: bit clock, edge timing, integrator
         if (samp) begin
            st_next.bit_cnt = (st_reg.bit_cnt == hcd_pkg::SAMPLES_PER_BIT - 4'h1) ? 4'h0 :
                              st_reg.bit_cnt + 4'h1;
            st_next.bclk = (st_reg.bit_cnt < hcd_pkg::BIT_HIGH);
            st_next.line_d = serial_in_i;
            if (rise) begin
               // Every rising edge restarts symbol timing
               st_next.per_cnt = 8'h00;
               st_next.sym_busy = 1'b1;
               st_next.smp_idx = 5'h00;
               st_next.nsmp = 4'h0;
               st_next.ones = 4'h0;
               case (st_reg.sync)
                  SY_SEARCH: begin
                     if (per_pre) begin
                        st_next.pre_cnt = st_reg.pre_cnt + 5'h01;
                        if (st_reg.pre_cnt >= hcd_pkg::PRE_LOCK - 5'h01) begin
                           st_next.sync = SY_ARMED;
                        end
                     end else begin
                        st_next.pre_cnt = 5'h00;
                     end
                  end
                  SY_ARMED: begin
                     if (!per_pre) begin
                        st_next.sync = SY_SEARCH;
                        st_next.pre_cnt = 5'h00;
                     end
                  end
                  SY_DATA: ;
                  default: st_next.sync = SY_SEARCH;
               endcase
            end else begin
               if (st_reg.per_cnt != 8'hff) begin
                  st_next.per_cnt = st_reg.per_cnt + 8'h01;
               end
               // A silent line ends any frame in progress
               if (st_reg.sync != SY_SEARCH && st_reg.per_cnt >= hcd_pkg::IDLE_SAMPLES) begin
                  st_next.sync = SY_SEARCH;
                  st_next.pre_cnt = 5'h00;
               end
               if (st_reg.sym_busy) begin
                  st_next.smp_idx = idx_n;
                  if (idx_n == smp_pos) begin
                     st_next.ones = ones_tot;
                     st_next.nsmp = st_reg.nsmp + 4'h1;
                     if (st_reg.nsmp == hcd_pkg::SYM_SAMPLES - 4'h1) begin
                        st_next.sym_busy = 1'b0;
                        sym_done = 1'b1;
                     end
                  end
               end
            end
         end
         // Hand the pending symbol to the buffer
         if (st_reg.pend && fifo_in_ready) begin
            st_next.pend = 1'b0;
         end
         // Symbol decision: precode pulses never reach eight samples
         if (sym_done && st_next.sync != SY_SEARCH) begin
            sym_bad = (ones_tot > hcd_pkg::ZERO_MAX) && (ones_tot < hcd_pkg::ONE_MIN);
            if (sym_bad) begin
               st_next.sync = SY_SEARCH;
               st_next.pre_cnt = 5'h00;
            end else begin
               st_next.pend = 1'b1;
               st_next.pend_sym.first = (st_reg.sync == SY_ARMED);
               st_next.pend_sym.bit_val = (ones_tot >= hcd_pkg::ONE_MIN);
               st_next.sync = SY_DATA;
               st_next.sym_cnt = (st_reg.sync == SY_ARMED) ? 6'h01 : st_reg.sym_cnt + 6'h01;
               if (st_reg.sync == SY_DATA && st_reg.sym_cnt == hcd_pkg::FRAME_SYMS - 6'h01) begin
                  st_next.sync = SY_SEARCH;
                  st_next.pre_cnt = 5'h00;
               end
            end
         end
         // Frame assembly and evaluation
         case (st_reg.asm_st)
            AS_COLLECT: begin
               if (fifo_out_valid) begin
                  st_next.shreg = fifo_out.first ? {47'h0, fifo_out.bit_val} :
                                  {st_reg.shreg[46:0], fifo_out.bit_val};
                  st_next.fr_cnt = fifo_out.first ? 6'h01 : st_reg.fr_cnt + 6'h01;
                  if (st_next.fr_cnt == hcd_pkg::FRAME_SYMS) begin
                     st_next.asm_st = AS_EVAL;
                  end
               end
            end
            AS_EVAL: begin
               st_next.asm_st = AS_COLLECT;
               st_next.fr_cnt = 6'h00;
               if (!st_reg.enc_mode) begin
                  if (st_reg.learn_act && !st_reg.learned) begin
                     // Learn: whole code and check byte in one write
                     st_next.we = 1'b1;
                     st_next.wbank = st_reg.next_bank;
                     st_next.wdata = '{code: sec, chk: hcd_pkg::hcd_chk(sec)};
                     st_next.next_bank = st_reg.next_bank + 2'h1;
                     st_next.learned = 1'b1;
                     st_next.lamp_n = hcd_pkg::LAMP_OFF;
                  end else if (match_any && fn1 == fn2) begin
                     load_fn = (fn1 != hcd_pkg::FUNC_NONE);
                     kill_fn = (fn1 == hcd_pkg::FUNC_NONE);
                  end
               end
            end
            default: st_next.asm_st = AS_COLLECT;
         endcase
         // Program pin: learn in decoder mode, code generation in encoder mode
         st_next.program_request_pin_d = program_request_pin_i;
         if (!st_reg.enc_mode) begin
            if (program_request_pin_rise) begin
               st_next.learn_act = 1'b1;
               st_next.learned = 1'b0;
               st_next.lamp_n = 1'b0;
            end else if (!program_request_pin_i) begin
               st_next.learn_act = 1'b0;
            end
         end else begin
            if (program_request_pin_rise && !st_reg.enc_busy) begin
               st_next.enc_busy = 1'b1;
               st_next.lamp_n = 1'b0;
            end else if (st_reg.enc_busy && btick) begin
               // Lamp stays lit for the rest of the bit, then the code lands
               st_next.we = 1'b1;
               st_next.wbank = 2'h0;
               st_next.wdata = '{code: st_reg.lfsr, chk: hcd_pkg::hcd_chk(st_reg.lfsr)};
               st_next.enc_busy = 1'b0;
               st_next.lamp_n = hcd_pkg::LAMP_OFF;
            end
         end
         // Function lines: reload keeps them active through the frame gap
         if (load_fn) begin
            st_next.func_n = {fn1[0], fn1[1], fn1[2], fn1[3]};
            st_next.hold = hcd_pkg::HOLD_BITS;
         end else if (kill_fn) begin
            st_next.func_n = hcd_pkg::FUNC_IDLE;
            st_next.hold = 10'h000;
         end else if (btick) begin
            if (st_reg.hold != 10'h000) begin
               st_next.hold = st_reg.hold - 10'h001;
            end else begin
               st_next.func_n = hcd_pkg::FUNC_IDLE;
            end
         end
      end
   end

   // ==========================================================
   // State register; the mode is caught while reset is held
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
         st_reg.func_n <= hcd_pkg::FUNC_IDLE;
         st_reg.lamp_n <= hcd_pkg::LAMP_OFF;
         st_reg.lfsr <= hcd_pkg::LFSR_SEED;
         st_reg.enc_mode <= config_select_pin_i;
      end else begin
         st_reg <= st_next;
      end
   end

   assign function_lines_n_o = st_reg.func_n;
   assign status_lamp_n_o = st_reg.lamp_n;
   assign bit_clock_o = st_reg.bclk;
   assign decoder_mode_o = !st_reg.enc_mode;

   // ==========================================================
   // Symbol buffer and code store
   hcd_fifo #(
      .WIDTH($bits(hcd_pkg::hcd_sym_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .in_valid_i(st_reg.pend),
      .in_ready_o(fifo_in_ready),
      .in_data_i(st_reg.pend_sym),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out)
   );

   hcd_store #(
      .BANKS(hcd_pkg::BANKS)
   ) u_store (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .we_i(st_reg.we),
      .wbank_i(st_reg.wbank),
      .wdata_i(st_reg.wdata),
      .banks_o(banks)
   );

   // ==========================================================
   // Checks
   logic [3:0] samp_since;
   logic [10:0] hold_ticks;
   wire hold_end = btick && (st_reg.hold == 10'h000); // Hold may lapse on an eval cycle

   // Helper counters: samples per bit tick, bit ticks since last load
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         samp_since <= 4'h9;
         hold_ticks <= 11'h000;
      end else begin
         if (btick) begin
            samp_since <= 4'h0;
         end else if (samp) begin
            samp_since <= samp_since + 4'h1;
         end
         if (load_fn) begin
            hold_ticks <= 11'h000;
         end else if (btick && hold_ticks != 11'h7ff) begin
            hold_ticks <= hold_ticks + 11'h001;
         end
      end
   end

   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_eval_decode;
      ce_i && st_reg.asm_st == AS_EVAL && !st_reg.enc_mode && !(st_reg.learn_act && !st_reg.learned);
   endsequence

   sequence s_learn_write;
      ce_i && st_reg.asm_st == AS_EVAL && !st_reg.enc_mode && st_reg.learn_act && !st_reg.learned;
   endsequence

   mode_catch_a: assert property ($fell(sys_rst_i) |-> decoder_mode_o == !$past(config_select_pin_i))
      else $error("mode does not follow configuration pin at reset");
   no_match_a: assert property (s_eval_decode and !match_any and !hold_end
      |=> $stable(function_lines_n_o))
      else $error("function lines moved without a code match");
   pkt_differ_a: assert property (s_eval_decode and fn1 != fn2 and !hold_end
      |=> $stable(function_lines_n_o))
      else $error("function lines moved on differing packets");
   hold_min_a: assert property ($rose(&function_lines_n_o) && !$past(kill_fn) |-> $past(hold_ticks) >= 11'h300)
      else $error("function line released before 768 bit clocks");
   kill_fn_a: assert property (s_eval_decode and match_any and fn1 == fn2 and fn1 == 4'hf |=> function_lines_n_o == 4'hf)
      else $error("invalid function data did not release lines");
   bit_rate_a: assert property (btick |-> samp_since == 4'h9)
      else $error("bit tick not every ten samples");
   sym_one_a: assert property (sym_done && st_reg.sync != SY_SEARCH && ones_tot >= 4'h5
      |=> st_reg.pend_sym.bit_val)
      else $error("majority high symbol not decoded as one");
   pre_break_a: assert property (samp && rise && st_reg.sync == SY_ARMED && !per_pre |=> st_reg.sync == SY_SEARCH)
      else $error("broken precode did not restart search");
   learn_store_a: assert property (s_learn_write |=> st_reg.we && status_lamp_n_o ##1 !st_reg.we)
      else $error("learned code not written once with lamp off");
   fifo_bank_a: assert property (s_learn_write |=> st_reg.next_bank == $past(st_reg.next_bank) + 2'h1)
      else $error("bank pointer did not advance after learning");
   enc_bank_a: assert property (st_reg.we && st_reg.enc_mode
      |-> st_reg.wbank == 2'h0 && status_lamp_n_o)
      else $error("encoder wrote outside the first bank");
endmodule

// >>> hdl/hcd_fifo.sv
`timescale 1ns/1ns
module hcd_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } hcd_fifo_st_t;

   hcd_fifo_st_t st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // ==========================================================
   // Handshake; depth must be a power of two so pointers wrap
   assign in_ready_o = (st_reg.cnt != FULL);
   assign out_valid_o = (st_reg.cnt != '0);
   assign out_data_o = mem[st_reg.rp];
   assign push = ce_i && in_valid_i && in_ready_o;
   assign pop = ce_i && out_valid_o && out_ready_i;

   // Pointer and fill level update
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wp = st_reg.wp + AW'(1);
      end
      if (pop) begin
         st_next.rp = st_reg.rp + AW'(1);
      end
      case ({push, pop})
         2'b10: st_next.cnt = st_reg.cnt + (AW+1)'(1);
         2'b01: st_next.cnt = st_reg.cnt - (AW+1)'(1);
         default: st_next.cnt = st_reg.cnt;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage needs no reset; only words below the fill level are read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[st_reg.wp] <= in_data_i;
      end
   end
endmodule

// >>> hdl/hcd_store.sv
`timescale 1ns/1ns
module hcd_store #(
   parameter int BANKS = 4
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Write port, one whole bank per write
   input wire logic we_i,
   input wire logic [$clog2(BANKS)-1:0] wbank_i,
   input wire hcd_pkg::hcd_bank_t wdata_i,
   // All banks, read in parallel for matching
   output hcd_pkg::hcd_bank_t [BANKS-1:0] banks_o
);
   hcd_pkg::hcd_bank_t mem [BANKS];

   // ==========================================================
   // Reset leaves every bank erased, with a failing check byte
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int b = 0; b < BANKS; b++) begin
            mem[b] <= '{code: '0, chk: hcd_pkg::ERASED_CHK};
         end
      end else if (ce_i && we_i) begin
         mem[wbank_i] <= wdata_i;
      end
   end

   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         banks_o[b] = mem[b];
      end
   end
endmodule

// >>> include/hcd_pkg.sv
package hcd_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 32'h14;            // 20 ns system clock
   localparam int SCLK_PERIOD_NS = 32'hc350;         // 50000 ns sample period
   localparam int SCLK_DIV_CYC = SCLK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [3:0] SAMPLES_PER_BIT = 4'ha;    // Bit clock is sample rate / 10
   localparam logic [3:0] BIT_HIGH = 4'h5;
   localparam logic [9:0] HOLD_BITS = 10'h300;       // 768 bit clocks
   localparam logic [7:0] BLANK_BITS = 8'h96;        // Gap between frames, covered by hold

   // ==========================================================
   // Symbol and frame format
   localparam logic [4:0] SYM_FIRST = 5'h02;         // First integrator sample after the edge
   localparam logic [4:0] SYM_SPACING = 5'h03;
   localparam logic [3:0] SYM_SAMPLES = 4'h8;
   localparam logic [3:0] ONE_MIN = 4'h5;
   localparam logic [3:0] ZERO_MAX = 4'h3;
   localparam logic [7:0] PRE_PER_MIN = 8'h0f;       // Precode period window in samples
   localparam logic [7:0] PRE_PER_MAX = 8'h18;
   localparam logic [4:0] PRE_LOCK = 5'h08;          // Precode periods needed before arming
   localparam logic [7:0] IDLE_SAMPLES = 8'h2d;      // No edge this long breaks a frame
   localparam logic [5:0] FRAME_SYMS = 6'h30;        // 40 security + 4 + 4 function
   localparam logic [3:0] FUNC_NONE = 4'hf;

   // ==========================================================
   // Store, reset values and buffering
   localparam int BANKS = 32'h4;
   localparam int FIFO_DEPTH = 32'h10;
   localparam logic [7:0] ERASED_CHK = 8'hff;
   localparam logic [3:0] FUNC_IDLE = 4'hf;
   localparam logic LAMP_OFF = 1'b1;
   localparam logic [39:0] LFSR_SEED = 40'h00_0000_0001;

   typedef struct packed {
      logic first;
      logic bit_val;
   } hcd_sym_t;

   typedef struct packed {
      logic [39:0] code;
      logic [7:0] chk;
   } hcd_bank_t;

   // Error-detection byte kept beside each stored code
   function automatic logic [7:0] hcd_chk(input logic [39:0] c);
      return c[39:32] ^ c[31:24] ^ c[23:16] ^ c[15:8] ^ c[7:0];
   endfunction

endpackage
